//--- sceqc_pkg.sv
// sceqc_pkg: register map, limits and reset values of the compressor
package sceqc_pkg;
   localparam int REG_STRIDE = 4;
   localparam int R_CTRL     = 0;
   localparam int R_OGAIN    = 1;
   localparam int R_MKGAIN   = 2;
   localparam int R_ATK      = 3;
   localparam int R_REL      = 4;
   localparam int R_SMOOTH   = 5;
   localparam int R_DLY      = 6;
   localparam int R_RATIO    = 7;
   localparam int R_THR      = 8;
   localparam int R_LGAIN    = 9;
   localparam int R_LFREQ    = 10;
   localparam int R_HGAIN    = 11;
   localparam int R_HFREQ    = 12;
   localparam int R_PGAIN    = 13;
   localparam int R_PFREQ    = 14;
   localparam int R_PBW      = 15;
   localparam int R_METER    = 16;
   localparam int NREG       = 16;
   localparam int CTRL_ACT   = 0;
   localparam int CTRL_FB    = 1;
   // dB values are in tenths of a dB
   localparam int DB_OFF     = -32'sh320;
   localparam int DB_MAX     = 32'shF0;
   localparam int LVL_MIN    = -32'sh3C0;
   localparam int DB_PER_OCT = 32'sh3C;
   localparam int RATIO_INF  = 32'sh3DF;
   localparam int GAIN_ONE   = 32'sh100;
   localparam int ATK_UNIT_US = 32'h64;
   localparam int REL_UNIT_US = 32'h3E8;
   localparam int DLY_MAX_MS  = 32'h19;
   localparam logic signed [15:0] REG_LO [NREG] = '{16'sh0, -16'sh320,
      -16'sh320, 16'sh0, 16'sh0, 16'sh0, 16'sh0, 16'sh0, -16'sh316,
      -16'sh316, 16'sh0, -16'sh316, 16'sh0, -16'sh316, 16'sh0, 16'shA};
   localparam logic signed [15:0] REG_HI [NREG] = '{16'sh3, 16'shF0,
      16'shF0, 16'sh8E8, 16'shBB8, 16'sh8E8, 16'shFA, 16'sh3DF, 16'shF0,
      16'shF0, 16'sh7F, 16'shF0, 16'sh7F, 16'shF0, 16'sh7F, 16'sh1388};
   localparam logic signed [15:0] REG_RST [NREG] = '{16'sh1, 16'sh0,
      16'sh0, 16'sh64, 16'sh3E8, 16'sh0, 16'sh0, 16'sh1E, -16'shC8,
      16'sh0, 16'sh24, 16'sh0, 16'sh60, 16'sh0, 16'sh3C, 16'sh3E8};
endpackage

//--- sceqc_src.sv
// sceqc_src: upstream sample source and downstream sink model
`timescale 1ns/100ps
module sceqc_src
(
   input  wire logic               clk,
   output logic                    in_valid,
   output logic signed [15:0]      in_l,
   output logic signed [15:0]      in_r,
   input  wire logic               out_valid,
   input  wire logic signed [15:0] out_l,
   input  wire logic signed [15:0] out_r
);
   logic               got_v;
   logic signed [15:0] got_l;
   logic signed [15:0] got_r;

   // idle stream at time zero
   initial
   begin
      in_valid = 1'b0;
      in_l = 16'sh0;
      in_r = 16'sh0;
   end

   // one beat after gap idle cycles, then catch the answer
   task automatic send(input logic signed [15:0] l, r, input int gap);
      repeat (gap) @(posedge clk);
      in_valid <= 1'b1;
      in_l <= l;
      in_r <= r;
      @(posedge clk);
      in_valid <= 1'b0;
      in_l <= ~l; // stale lines toggle, so no false match
      in_r <= ~r;
      // sample mid-cycle: the next rising edge already drops out_valid
      @(negedge clk);
      got_v = out_valid;
      got_l = out_l;
      got_r = out_r;
      @(posedge clk);
   endtask
endmodule // sceqc_src

//--- sceqc_top.sv
// sceqc_top: stereo compressor with side-chain eq and ahb-lite registers
`timescale 1ns/100ps
module sceqc_top
   import sceqc_pkg::*;
#(
   parameter int SAMPLE_HZ = 48000
)
(
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic [31:0]             hrdata,
   input  wire logic               in_valid,
   input  wire logic signed [15:0] in_l,
   input  wire logic signed [15:0] in_r,
   output logic                    out_valid,
   output logic signed [15:0]      out_l,
   output logic signed [15:0]      out_r,
   output logic [15:0]             reduction
);
   localparam int DEPTH = DLY_MAX_MS * SAMPLE_HZ / 1000 + 1;
   localparam int AW    = $clog2(DEPTH);
   localparam int K0    = $clog2(SAMPLE_HZ / 100);

   if (SAMPLE_HZ < 8000 || SAMPLE_HZ > 192000)
   begin : g_chk
      $error("sample rate out of range");
   end

   typedef struct packed {
      logic [NREG-1:0][15:0] cfg;
      logic                  wpend;
      logic [3:0]            widx;
      logic [31:0]           rdata;
      logic [AW-1:0]         wp;
      logic signed [23:0]    lpl;
      logic signed [23:0]    lph;
      logic signed [23:0]    lpa;
      logic signed [23:0]    lpb;
      logic signed [23:0]    env;
      logic signed [23:0]    sm;
      logic signed [15:0]    ol;
      logic signed [15:0]    orr;
      logic                  ov;
   } sceqc_state_s;

   sceqc_state_s s_q;
   sceqc_state_s s_d;
   logic [1:0]   rsync_q;
   logic         rst_n;
   logic [31:0]  dmem [DEPTH];
   logic         take;
   logic         act;
   logic         fb;
   int           c_mono;
   int           c_lvl;
   int           c_over;
   int           c_tgt;

   // level of a magnitude, msb position plus 4-bit linear fraction
   function automatic int f_lvl(input logic [15:0] x);
      int p;
      int fr;
      p = -1;
      fr = 0;
      for (int i = 0; i < 16; i++)
         if (x[i])
            p = i;
      if (p < 0)
         return LVL_MIN;
      if (p >= 4)
         fr = int'(x >> (p - 4)) & 15;
      else
         fr = (int'(x) << (4 - p)) & 15;
      return DB_PER_OCT * (p - 15) + fr * DB_PER_OCT / 16;
   endfunction

   // tenths of a dB to a Q8 linear gain, mantissa interpolated
   function automatic int f_lin(input int db);
      int d;
      int q;
      int m;
      d = db - LVL_MIN;
      if (db < LVL_MIN)
         return 0;
      q = d / DB_PER_OCT + LVL_MIN / DB_PER_OCT;
      m = GAIN_ONE + (d % DB_PER_OCT) * GAIN_ONE / DB_PER_OCT;
      return (q >= 0) ? (m <<< q) : (m >>> -q);
   endfunction

   // one-pole lowpass, state in Q8, shift sets the corner
   function automatic int f_lp(input int s, input int x, input int k);
      return s + ((x * 256 - s) >>> k);
   endfunction

   // semitone index to lowpass shift; one octave per shift step
   function automatic int f_kf(input int n);
      int k;
      k = K0 - n / 12;
      if (k < 0)
         k = 0;
      if (k > 15)
         k = 15;
      return k;
   endfunction

   // time constant in samples to shift, zero gives instant response
   function automatic int f_kt(input int n);
      int k;
      k = 0;
      for (int i = 1; i < 24; i++)
         if (n >= (1 << i))
            k = i;
      return k;
   endfunction

   function automatic logic signed [15:0] f_sat(input int v);
      if (v > 32767)
         return 16'sh7FFF;
      if (v < -32768)
         return -16'sh8000;
      return 16'(v);
   endfunction

   // software writes are clamped to the legal range of each field
   function automatic logic [15:0] f_lim(input logic [31:0] w,
                                         input int i);
      int v;
      v = int'(signed'(w));
      if (v < REG_LO[i])
         v = REG_LO[i];
      if (v > REG_HI[i])
         v = REG_HI[i];
      return 16'(v);
   endfunction

   // reset release through two flops
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         rsync_q <= 2'h0;
      else
         rsync_q <= {rsync_q[0], 1'h1};
   assign rst_n = rsync_q[1];

   // delay line, left in the upper half of each word
   always_ff @(posedge clk)
      if (in_valid)
         dmem[s_q.wp] <= {in_l, in_r};

   assign act  = s_q.cfg[R_CTRL][CTRL_ACT];
   assign fb   = s_q.cfg[R_CTRL][CTRL_FB];
   assign take = hsel & hready & htrans[1] & (hsize == 3'h2);

   // next state: bus slave then one sample per in_valid
   always_comb
   begin
      int x1;
      int x2;
      int x3;
      int gl;
      int gh;
      int gp;
      int bw6;
      int ks;
      int gr;
      int mg;
      int tot;
      int g;
      int dsm;
      int rd;
      int ix;
      logic [31:0] dw;
      x1 = 0;
      x2 = 0;
      x3 = 0;
      gl = 0;
      gh = 0;
      gp = 0;
      bw6 = 0;
      ks = 0;
      gr = 0;
      mg = 0;
      tot = 0;
      g = 0;
      dsm = 0;
      rd = 0;
      ix = int'(haddr[7:2]);
      dw = 32'h0;
      c_mono = 0;
      c_lvl = 0;
      c_over = 0;
      c_tgt = 0;
      s_d = s_q;
      s_d.ov = in_valid;
      // write lands in the data phase; reads see it at once
      if (s_q.wpend)
         s_d.cfg[s_q.widx] = f_lim(hwdata, int'(s_q.widx));
      s_d.wpend = take & hwrite & (haddr[31:8] == 24'h0) & (ix < NREG);
      s_d.widx = haddr[5:2];
      if (take && !hwrite)
      begin
         s_d.rdata = 32'h0;
         if (haddr[31:8] == 24'h0 && ix < NREG)
            s_d.rdata = {{16{s_d.cfg[ix][15]}}, s_d.cfg[ix]};
         else if (haddr[31:8] == 24'h0 && ix == R_METER)
            s_d.rdata = {16'h0, reduction};
      end
      if (in_valid)
      begin
         // side chain source: last output or present input
         if (fb)
            c_mono = (int'(s_q.ol) + int'(s_q.orr)) >>> 1;
         else
            c_mono = (int'(in_l) + int'(in_r)) >>> 1;
         gl = f_lin(int'(signed'(s_q.cfg[R_LGAIN]))) - GAIN_ONE;
         gh = f_lin(int'(signed'(s_q.cfg[R_HGAIN]))) - GAIN_ONE;
         gp = f_lin(int'(signed'(s_q.cfg[R_PGAIN]))) - GAIN_ONE;
         // bass shelf adds a scaled lowpass of the signal
         s_d.lpl = 24'(f_lp(s_q.lpl, c_mono,
                            f_kf(int'(s_q.cfg[R_LFREQ]))));
         x1 = int'(f_sat(c_mono + ((gl * (s_d.lpl >>> 8)) >>> 8)));
         // treble shelf adds a scaled highpass residue
         s_d.lph = 24'(f_lp(s_q.lph, x1, f_kf(int'(s_q.cfg[R_HFREQ]))));
         x2 = int'(f_sat(x1 + ((gh * (x1 - (s_d.lph >>> 8))) >>> 8)));
         // peak band between corners half a bandwidth each side
         bw6 = int'(s_q.cfg[R_PBW]) * 6 / 1000;
         s_d.lpa = 24'(f_lp(s_q.lpa, x2,
                            f_kf(int'(s_q.cfg[R_PFREQ]) + bw6)));
         s_d.lpb = 24'(f_lp(s_q.lpb, x2,
                            f_kf(int'(s_q.cfg[R_PFREQ]) - bw6)));
         x3 = int'(f_sat(x2 + ((gp * ((s_d.lpa - s_d.lpb) >>> 8))
                               >>> 8)));
         c_lvl = f_lvl(16'((x3 < 0) ? -x3 : x3));
         c_over = c_lvl - int'(signed'(s_q.cfg[R_THR]));
         if (c_over > 0)
         begin
            if (int'(s_q.cfg[R_RATIO]) == RATIO_INF)
               c_tgt = c_over;
            else
               c_tgt = c_over - c_over * 10
                       / (int'(s_q.cfg[R_RATIO]) + 10);
         end
         // attack when reduction grows, release when it falls
         if (c_tgt * 256 > s_q.env)
            ks = f_kt(int'(s_q.cfg[R_ATK]) * SAMPLE_HZ
                      / (1000000 / ATK_UNIT_US));
         else
            ks = f_kt(int'(s_q.cfg[R_REL]) * SAMPLE_HZ
                      / (1000000 / REL_UNIT_US));
         s_d.env = 24'(f_lp(s_q.env, c_tgt, ks));
         // second pole only dominates when slower than the first
         s_d.sm = 24'(f_lp(s_q.sm, s_d.env >>> 8,
                           f_kt(int'(s_q.cfg[R_SMOOTH]) * SAMPLE_HZ
                                / (1000000 / ATK_UNIT_US))));
         gr = s_d.sm >>> 8;
         mg = int'(signed'(s_q.cfg[R_MKGAIN]));
         if (mg == DB_OFF)
            mg = 0;
         tot = int'(signed'(s_q.cfg[R_OGAIN])) + mg;
         if (tot > DB_MAX)
            tot = DB_MAX;
         if (int'(signed'(s_q.cfg[R_OGAIN])) != DB_OFF)
            g = f_lin(tot - gr);
         // main path reads the delay line, or the input at zero delay, never the equalizer
         dsm = int'(s_q.cfg[R_DLY]) * SAMPLE_HZ / 10000;
         rd = (int'(s_q.wp) >= dsm) ? int'(s_q.wp) - dsm
                                   : int'(s_q.wp) + DEPTH - dsm;
         dw = (dsm == 0) ? {in_l, in_r} : dmem[rd];
         s_d.wp = (int'(s_q.wp) == DEPTH - 1) ? '0 : AW'(int'(s_q.wp) + 1);
         if (act)
         begin
            s_d.ol = f_sat((int'(signed'(dw[31:16])) * g) >>> 8);
            s_d.orr = f_sat((int'(signed'(dw[15:0])) * g) >>> 8);
         end
         else
         begin
            s_d.ol = in_l;
            s_d.orr = in_r;
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         s_q <= '0;
         for (int i = 0; i < NREG; i++)
            s_q.cfg[i] <= REG_RST[i];
      end
      else
         s_q <= s_d;

   // zero-wait slave, always OKAY
   assign hreadyout = 1'h1;
   assign hresp     = 1'h0;
   assign hrdata    = s_q.rdata;
   assign out_valid = s_q.ov;
   assign out_l     = s_q.ol;
   assign out_r     = s_q.orr;
   assign reduction = 16'(s_q.sm >>> 8);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_bypass;
      in_valid && !act |=> out_l == $past(in_l) && out_r == $past(in_r);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass altered the sample");

   property p_gain_ignored;
      in_valid && !act && signed'(s_q.cfg[R_OGAIN]) == DB_OFF
      |=> out_l == $past(in_l);
   endproperty
   a_gain_ignored: assert property (p_gain_ignored)
      else $error("output gain acted while bypassed");

   property p_mute;
      in_valid && act && signed'(s_q.cfg[R_OGAIN]) == DB_OFF
      |=> out_l == 16'sh0 && out_r == 16'sh0 && out_valid;
   endproperty
   a_mute: assert property (p_mute)
      else $error("output gain off did not mute");

   property p_source;
      in_valid && fb |-> c_mono == ((int'(out_l) + int'(out_r)) >>> 1);
   endproperty
   a_source: assert property (p_source)
      else $error("feedback detector not fed by output");

   property p_thresh;
      in_valid && c_lvl <= signed'(s_q.cfg[R_THR]) |-> c_tgt == 0;
   endproperty
   a_thresh: assert property (p_thresh)
      else $error("reduction below threshold");

   property p_inf;
      in_valid && c_over > 0 && s_q.cfg[R_RATIO] == RATIO_INF
      |-> c_tgt == c_over;
   endproperty
   a_inf: assert property (p_inf)
      else $error("infinite ratio not limiting");

   property p_unity;
      in_valid && s_q.cfg[R_RATIO] == 16'h0 |-> c_tgt == 0;
   endproperty
   a_unity: assert property (p_unity)
      else $error("unity ratio reduced gain");

   property p_meter;
      take && !hwrite && haddr == R_METER * REG_STRIDE
      |=> hrdata == {16'h0, $past(reduction)};
   endproperty
   a_meter: assert property (p_meter)
      else $error("meter read mismatch");

   property p_stereo;
      in_valid && act && in_l == in_r && s_q.cfg[R_DLY] == 16'h0
      |=> out_l == out_r;
   endproperty
   a_stereo: assert property (p_stereo)
      else $error("channels got different gains");

   property p_attack;
      in_valid && s_q.cfg[R_ATK] == 16'h0 && s_q.cfg[R_SMOOTH] == 16'h0
      && c_tgt * 256 > s_q.env |=> reduction == 16'($past(c_tgt));
   endproperty
   a_attack: assert property (p_attack)
      else $error("zero attack not instant");

endmodule // sceqc_top

//--- tb.sv
// tb: register, bypass, gain and dynamics tests of the compressor
`timescale 1ns/100ps
module tb;
   typedef struct packed
   {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } sceqc_row_s;

   logic               clk;
   logic               nrst;
   logic               hsel;
   logic [31:0]        haddr;
   logic [1:0]         htrans;
   logic               hwrite;
   logic [2:0]         hsize;
   logic [31:0]        hwdata;
   logic               hreadyout;
   logic               hresp;
   logic [31:0]        hrdata;
   logic               in_valid;
   logic signed [15:0] in_l;
   logic signed [15:0] in_r;
   logic               out_valid;
   logic signed [15:0] out_l;
   logic signed [15:0] out_r;
   logic [15:0]        reduction;
   wire                hready;
   logic [31:0]        rd;
   logic [15:0]        ff;
   int                 k;
   int                 n_errors;
   int                 n_tests;

   // reads after optional write: reset values, clamps, odd places
   localparam sceqc_row_s rows [23] = '{
      '{1'b0, 8'h00, 32'h0, 32'h1},
      '{1'b0, 8'h0C, 32'h0, 32'h64},
      '{1'b0, 8'h10, 32'h0, 32'h3E8},
      '{1'b0, 8'h1C, 32'h0, 32'h1E},
      '{1'b0, 8'h20, 32'h0, 32'hFFFFFF38},
      '{1'b0, 8'h28, 32'h0, 32'h24},
      '{1'b0, 8'h3C, 32'h0, 32'h3E8},
      '{1'b1, 8'h04, 32'h12C, 32'hF0},
      '{1'b1, 8'h04, 32'hFFFFFC7C, 32'hFFFFFCE0},
      '{1'b1, 8'h08, 32'h12C, 32'hF0},
      '{1'b1, 8'h0C, 32'hBB8, 32'h8E8},
      '{1'b1, 8'h10, 32'hFA0, 32'hBB8},
      '{1'b1, 8'h14, 32'h1388, 32'h8E8},
      '{1'b1, 8'h18, 32'h12C, 32'hFA},
      '{1'b1, 8'h1C, 32'h7D0, 32'h3DF},
      '{1'b1, 8'h20, 32'hFFFFFC18, 32'hFFFFFCEA},
      '{1'b1, 8'h24, 32'h1F4, 32'hF0},
      '{1'b1, 8'h2C, 32'hFFFFFC18, 32'hFFFFFCEA},
      '{1'b1, 8'h34, 32'h1F4, 32'hF0},
      '{1'b1, 8'h38, 32'hC8, 32'h7F},
      '{1'b1, 8'h3C, 32'h5, 32'hA},
      '{1'b1, 8'h40, 32'h5, 32'h0},
      '{1'b1, 8'h80, 32'h5, 32'h0}};

   // base setup: bypass, mute, instant times, no compression
   localparam sceqc_row_s base [12] = '{
      '{1'b1, 8'h04, 32'hFFFFFCE0, 32'h0}, '{1'b1, 8'h08, 32'hFFFFFCE0, 32'h0},
      '{1'b1, 8'h0C, 32'h0, 32'h0}, '{1'b1, 8'h10, 32'h0, 32'h0},
      '{1'b1, 8'h14, 32'h0, 32'h0}, '{1'b1, 8'h18, 32'h0, 32'h0},
      '{1'b1, 8'h1C, 32'h0, 32'h0}, '{1'b1, 8'h20, 32'hF0, 32'h0},
      '{1'b1, 8'h24, 32'hF0, 32'h0}, '{1'b1, 8'h2C, 32'h0, 32'h0},
      '{1'b1, 8'h34, 32'h0, 32'h0}, '{1'b1, 8'h00, 32'h0, 32'h0}};

   assign hready = hreadyout; // single slave drives the bus ready

   sceqc_top dut_u (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .in_valid(in_valid), .in_l(in_l), .in_r(in_r),
      .out_valid(out_valid), .out_l(out_l), .out_r(out_r),
      .reduction(reduction));

   sceqc_src src_u (.clk(clk), .in_valid(in_valid), .in_l(in_l),
      .in_r(in_r), .out_valid(out_valid), .out_l(out_l), .out_r(out_r));

   // 125 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // one single word transfer; address held until ready is seen
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic burst(input int n, input logic signed [15:0] v);
      repeat (n) src_u.send(v, v, 0);
   endtask

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles used
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      stop_test();
   end

   initial
   begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
      nrst = 1'b0;
      n_errors = 0;
      n_tests = 0;
      repeat (10) @(posedge clk);
      check({15'h0, out_valid, reduction}, 32'h0);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rows[i])
      begin
         if (rows[i].w)
            ahb(1'b1, rows[i].a, rows[i].d);
         ahb(1'b0, rows[i].a, 32'h0);
         check(rd, rows[i].e);
         check({31'h0, hresp}, 32'h0);
      end
      foreach (base[i])
         ahb(1'b1, base[i].a, base[i].d);
      // bypassed and muted: input must pass unchanged
      src_u.send(16'sd1000, -16'sd2000, 0);
      check({31'h0, src_u.got_v}, 32'h1);
      check(src_u.got_l, 32'd1000);
      check(src_u.got_r, -32'sd2000);
      ahb(1'b1, 8'h00, 32'h1);
      src_u.send(16'sd1000, -16'sd2000, 2);
      check(src_u.got_l, 32'h0);
      ahb(1'b1, 8'h04, 32'h0);
      src_u.send(16'sd1000, -16'sd2000, 0);
      check(src_u.got_r, -32'sd2000);
      check({16'h0, reduction}, 32'h0);
      // +24 plus +24 must cap at +24 dB, about 15.85 times
      ahb(1'b1, 8'h04, 32'hF0);
      ahb(1'b1, 8'h08, 32'hF0);
      src_u.send(16'sd100, 16'sd100, 0);
      check({31'h0, src_u.got_l > 1500 && src_u.got_l < 1700}, 1);
      ahb(1'b1, 8'h04, 32'h0);
      ahb(1'b1, 8'h08, 32'hFFFFFCE0);
      ahb(1'b1, 8'h20, 32'hFFFFFF38);
      ahb(1'b1, 8'h1C, 32'h1E);
      // flat side chain, else the bass boost keeps the detector busy
      ahb(1'b1, 8'h24, 32'h0);
      burst(20, 16'sd20000);
      check(src_u.got_l, src_u.got_r);
      check({31'h0, reduction != 16'h0}, 1);
      check({31'h0, src_u.got_l < 16'sd20000}, 1);
      ff = reduction;
      // feedback detects the compressed output, so less reduction
      ahb(1'b1, 8'h00, 32'h3);
      burst(20, 16'sd20000);
      check({31'h0, reduction < ff}, 1);
      ahb(1'b1, 8'h00, 32'h1);
      ahb(1'b1, 8'h10, 32'hBB8);
      burst(20, 16'sd20000);
      burst(1, 16'sd0);
      check({31'h0, reduction != 16'h0}, 1);
      ahb(1'b1, 8'h10, 32'h0);
      burst(2, 16'sd0);
      check({16'h0, reduction}, 32'h0);
      ahb(1'b1, 8'h0C, 32'h8E8);
      burst(1, 16'sd20000);
      check({31'h0, reduction < ff}, 1);
      ahb(1'b1, 8'h0C, 32'h0);
      burst(2, 16'sd0);
      ahb(1'b1, 8'h14, 32'h8E8);
      burst(1, 16'sd20000);
      check({31'h0, reduction < ff}, 1);
      // 1.0 ms main path delay is 48 samples at 48 kHz
      ahb(1'b1, 8'h14, 32'h0);
      ahb(1'b1, 8'h20, 32'hF0);
      ahb(1'b1, 8'h18, 32'hA);
      burst(60, 16'sd0);
      burst(1, 16'sd1000);
      k = 0;
      while (k < 60 && src_u.got_l !== 16'sd1000)
      begin
         k++;
         burst(1, 16'sd0);
      end
      check({31'h0, k >= 47 && k <= 49}, 1);
      stop_test();
   end
endmodule // tb
